// *** rtl/sbsc_pkg.sv ***
// Purpose: constants shared by the serial buffer status and control block
// Assumes: 32-bit APB register bus, 10 MHz peripheral clock
// Notes: offsets are byte addresses of aligned words
package sbsc_pkg;
    // register byte offsets
    localparam logic [11:0] ADDR_STATUS = 12'h000;
    localparam logic [11:0] ADDR_CTRL1 = 12'h004;
    localparam logic [11:0] ADDR_CTRL2 = 12'h008;
    localparam logic [11:0] ADDR_DATA = 12'h00c;
    localparam logic [11:0] ADDR_INT_STAT = 12'h010;
    localparam logic [11:0] ADDR_INT_MASK = 12'h014;
    // status register fields
    localparam int ST_RBF = 0;
    localparam int ST_TBF = 1;
    localparam int ST_RX_EMPTY = 5;
    localparam int ST_SHIFT_IDLE = 7;
    localparam int ST_ENABLE = 15;
    // control one fields
    localparam int C1_BITS = 13;
    localparam int C1_SCK_DIS = 12;
    localparam int C1_SDO_DIS = 11;
    localparam int C1_WIDE = 10;
    localparam int C1_MASTER = 5;
    // control two fields
    localparam int C2_ENH = 0;
    // interrupt status and mask fields
    localparam int INT_BITS = 2;
    localparam int INT_RX_WORD = 0;
    localparam int INT_TX_LOAD = 1;
    // reset values
    localparam logic [C1_BITS-1:0] CTRL1_RST = 13'h0000;
    localparam logic [INT_BITS-1:0] INT_MASK_RST = 2'h0;
    // fifo depth in enhanced buffer mode
    localparam int FIFO_DEPTH = 8;
    // serial clock timing in master mode
    localparam int CLK_PERIOD_NS = 100;
    localparam int SCK_HALF_NS = 400;
    localparam int SCK_HALF_CYC = (SCK_HALF_NS / CLK_PERIOD_NS < 1) ? 1 :
        SCK_HALF_NS / CLK_PERIOD_NS;
    // shift engine states
    typedef enum logic [1:0] {SBSC_IDLE, SBSC_SHIFT, SBSC_TAIL} sbsc_state_t;
endpackage

// *** rtl/sbsc_top.sv ***
// Purpose: buffer status flags, data location and control one of a
//          serial peripheral, with a mode 0 shift engine behind them
// Assumes: serial clock and data in come from outside and are synchronised
// Notes: fifo depth must be a power of two
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - In standard mode a write to the data location loads the holding buffer and sets the transmit full flag.
// - In standard mode the transmit full flag clears when the word moves into the shift register.
// - In enhanced mode the transmit full flag sets only when a write fills the last free fifo entry.
// - In enhanced mode the transmit full flag clears as soon as one fifo entry is free again.
// - In standard mode the receive full flag sets when a finished word moves into the receive holding buffer.
// - In standard mode the receive full flag clears when software reads the data location.
// - In enhanced mode the receive full flag sets only when a received word fills the last receive fifo entry.
// - In enhanced mode the receive full flag clears once one receive fifo entry is free.
module sbsc_top
    import sbsc_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH,
    parameter int HALF_CYC = SCK_HALF_CYC
)
(
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o,
    // serial pins
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe_o,
    input wire logic sdi_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    // interrupt
    output logic irq_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam int NARROW_CYC = 15 * HALF_CYC;
    localparam int WIDE_CYC = 31 * HALF_CYC;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [C1_BITS-1:0] ctrl1;
        logic enable;
        logic enh;
        logic [INT_BITS-1:0] int_stat;
        logic [INT_BITS-1:0] int_mask;
        logic irq;
        logic [DEPTH-1:0][15:0] tx_mem;
        logic [AW-1:0] tx_rd;
        logic [AW-1:0] tx_wr;
        logic [CW-1:0] tx_cnt;
        logic [DEPTH-1:0][15:0] rx_mem;
        logic [AW-1:0] rx_rd;
        logic [AW-1:0] rx_wr;
        logic [CW-1:0] rx_cnt;
        sbsc_state_t st;
        logic [15:0] shift;
        logic capt;
        logic [4:0] bitn;
        logic [7:0] div;
        logic sck;
        logic sck_oe;
        logic sdo_oe;
        logic [1:0] sck_sync;
        logic [1:0] sdi_sync;
        logic sck_prev;
    } sbsc_regs_t;

    sbsc_regs_t r;
    sbsc_regs_t n;

    // limits, full flags, fifo strobes and serial edges used by several paths
    logic [CW-1:0] lim;
    logic tbf, rbf, wide, master;
    logic tx_push, tx_pop, rx_push, rx_pop;
    logic rise, fall;
    logic [15:0] rx_word;

    // true when the address names an implemented register
    function automatic logic addr_hit(input logic [11:0] a);
        if (a == ADDR_STATUS || a == ADDR_CTRL1 || a == ADDR_CTRL2)
            return 1'b1;
        else if (a == ADDR_DATA || a == ADDR_INT_STAT || a == ADDR_INT_MASK)
            return 1'b1;
        else
            return 1'b0;
    endfunction

    // buffer limits and full flags from the held counts
    assign lim = r.enh ? CW'(DEPTH) : CW'(1);
    assign tbf = (r.tx_cnt == lim);
    assign rbf = (r.rx_cnt == lim);
    assign wide = r.ctrl1[C1_WIDE];
    assign master = r.ctrl1[C1_MASTER];

    // next state of every register
    always_comb
    begin
        logic setup, done, wr_en, rd_en;
        logic m_rise, m_fall;
        logic [15:0] stat;
        logic [INT_BITS-1:0] clr;
        logic [INT_BITS-1:0] ev;
        setup = psel_i & ~penable_i;
        done = psel_i & penable_i & r.pready;
        wr_en = done & pwrite_i;
        rd_en = done & ~pwrite_i;
        m_rise = 1'b0;
        m_fall = 1'b0;
        stat = 16'h0000;
        clr = '0;
        ev = '0;
        n = r;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        rx_word = {r.shift[14:0], r.sdi_sync[1]};

        // pin synchronisers, only the second stage is used
        n.sck_sync = {r.sck_sync[0], sck_i};
        n.sdi_sync = {r.sdi_sync[0], sdi_i};
        n.sck_prev = r.sck_sync[1];

        // master clock divider runs while a word is on the wire
        if (r.st != SBSC_IDLE && master)
        begin
            if (r.div == 8'(HALF_CYC - 1))
            begin
                n.div = 8'h00;
                n.sck = ~r.sck;
                m_rise = ~r.sck;
                m_fall = r.sck;
            end
            else
                n.div = r.div + 8'h01;
        end
        rise = master ? m_rise : (r.sck_sync[1] & ~r.sck_prev);
        fall = master ? m_fall : (~r.sck_sync[1] & r.sck_prev);

        // shift engine, mode 0: sample on rise, shift out on fall
        case (r.st)
            SBSC_IDLE:
            begin
                n.sck = 1'b0;
                n.div = 8'h00;
                if (r.enable && r.tx_cnt != '0)
                begin
                    tx_pop = 1'b1;
                    n.shift = wide ? r.tx_mem[r.tx_rd] :
                        {r.tx_mem[r.tx_rd][7:0], 8'h00};
                    n.bitn = 5'd0;
                    n.st = SBSC_SHIFT;
                end
            end
            SBSC_SHIFT:
            begin
                if (!r.enable)
                    n.st = SBSC_IDLE;
                else if (rise)
                begin
                    if (r.bitn == (wide ? 5'd15 : 5'd7))
                    begin
                        rx_push = (r.rx_cnt < lim);
                        n.st = SBSC_TAIL;
                    end
                    else
                    begin
                        n.capt = r.sdi_sync[1];
                        n.bitn = r.bitn + 5'd1;
                    end
                end
                else if (fall)
                    n.shift = {r.shift[14:0], r.capt};
            end
            SBSC_TAIL:
            begin
                if (fall || !r.enable)
                    n.st = SBSC_IDLE;
            end
            default:
                n.st = SBSC_IDLE;
        endcase

        // transmit fifo, a write past the limit is dropped
        tx_push = wr_en && paddr_i == ADDR_DATA && r.tx_cnt < lim;
        if (tx_push)
        begin
            n.tx_mem[r.tx_wr] = pwdata_i[15:0];
            n.tx_wr = r.tx_wr + AW'(1);
        end
        if (tx_pop)
            n.tx_rd = r.tx_rd + AW'(1);
        n.tx_cnt = r.tx_cnt + CW'(tx_push) - CW'(tx_pop);

        // receive fifo, a word arriving while full is discarded
        rx_pop = rd_en && paddr_i == ADDR_DATA && r.rx_cnt != '0;
        if (rx_push)
        begin
            n.rx_mem[r.rx_wr] = wide ? rx_word : {8'h00, rx_word[7:0]};
            n.rx_wr = r.rx_wr + AW'(1);
        end
        if (rx_pop)
            n.rx_rd = r.rx_rd + AW'(1);
        n.rx_cnt = r.rx_cnt + CW'(rx_push) - CW'(rx_pop);

        // register writes
        if (wr_en)
        begin
            if (paddr_i == ADDR_STATUS)
                n.enable = pwdata_i[ST_ENABLE];
            else if (paddr_i == ADDR_CTRL1)
                n.ctrl1 = pwdata_i[C1_BITS-1:0];
            else if (paddr_i == ADDR_CTRL2)
                n.enh = pwdata_i[C2_ENH];
            else if (paddr_i == ADDR_INT_STAT)
                clr = pwdata_i[INT_BITS-1:0];
            else if (paddr_i == ADDR_INT_MASK)
                n.int_mask = pwdata_i[INT_BITS-1:0];
        end

        // sticky events, a new event beats a clear in the same cycle
        ev[INT_RX_WORD] = rx_push;
        ev[INT_TX_LOAD] = tx_pop;
        n.int_stat = (r.int_stat & ~clr) | ev;
        n.irq = |(n.int_stat & n.int_mask);

        // pin drive enables
        n.sdo_oe = r.enable & ~r.ctrl1[C1_SDO_DIS];
        n.sck_oe = r.enable & master & ~r.ctrl1[C1_SCK_DIS];

        // apb answer, ready one cycle after setup
        stat[ST_RBF] = rbf;
        stat[ST_TBF] = tbf;
        stat[ST_RX_EMPTY] = (r.rx_cnt == '0);
        stat[ST_SHIFT_IDLE] = (r.st == SBSC_IDLE);
        stat[ST_ENABLE] = r.enable;
        n.pready = setup;
        n.pslverr = setup & ~addr_hit(paddr_i);
        n.prdata = 32'h00000000;
        if (setup)
        begin
            if (paddr_i == ADDR_STATUS)
                n.prdata = {16'h0000, stat};
            else if (paddr_i == ADDR_CTRL1)
                n.prdata = {19'h00000, r.ctrl1};
            else if (paddr_i == ADDR_CTRL2)
                n.prdata = {31'h00000000, r.enh};
            else if (paddr_i == ADDR_DATA)
                n.prdata = {16'h0000, r.rx_mem[r.rx_rd]};
            else if (paddr_i == ADDR_INT_STAT)
                n.prdata = {30'h00000000, r.int_stat};
            else if (paddr_i == ADDR_INT_MASK)
                n.prdata = {30'h00000000, r.int_mask};
        end
    end

    // state register
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            r <= '0;
            r.ctrl1 <= CTRL1_RST;
            r.int_mask <= INT_MASK_RST;
        end
        else
            r <= n;
    end

    // outputs straight from flip-flops
    assign pready_o = r.pready;
    assign prdata_o = r.prdata;
    assign pslverr_o = r.pslverr;
    assign sck_o = r.sck;
    assign sck_oe_o = r.sck_oe;
    assign sdo_o = r.shift[15];
    assign sdo_oe_o = r.sdo_oe;
    assign irq_o = r.irq;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (reset_i);

    // standard mode transmit flag follows write and load
    a_tx_std_set: assert property (!r.enh && tx_push && !tx_pop |=> tbf)
        else $error("transmit full not set after write");
    a_tx_std_clear: assert property (!r.enh && tx_pop |=> !tbf)
        else $error("transmit full not cleared after load");
    // enhanced mode transmit flag at the last entry
    a_tx_enh_full: assert property (r.enh && tx_push && !tx_pop &&
        r.tx_cnt == CW'(DEPTH - 1) |=> tbf && r.tx_cnt == CW'(DEPTH))
        else $error("transmit full not set at last entry");
    a_tx_enh_free: assert property (r.enh && tbf && tx_pop |=> !tbf)
        else $error("transmit full not cleared on free entry");
    // receive flag in both modes
    a_rx_std_set: assert property (!r.enh && rx_push |=> rbf ##1
        (rbf || $past(rx_pop)))
        else $error("receive full not set after word");
    a_rx_std_clear: assert property (!r.enh && rx_pop |=> !rbf)
        else $error("receive full not cleared after read");
    a_rx_enh_full: assert property (r.enh && rx_push && !rx_pop &&
        r.rx_cnt == CW'(DEPTH - 1) |=> rbf)
        else $error("receive full not set at last entry");
    a_rx_enh_free: assert property (r.enh && rbf && rx_pop |=> !rbf)
        else $error("receive full not cleared on free entry");
    // word length counted in rising serial edges
    a_word_len: assert property (rx_push |->
        r.bitn == (wide ? 5'd15 : 5'd7) && r.st == SBSC_SHIFT)
        else $error("word closed at wrong bit count");
    a_narrow_time: assert property (tx_pop && master && !wide
        |-> ##NARROW_CYC (rise && r.bitn == 5'd7 && r.st == SBSC_SHIFT))
        else $error("narrow word closed at wrong time");
    a_wide_time: assert property (tx_pop && master && wide
        |-> ##WIDE_CYC (rise && r.bitn == 5'd15 && r.st == SBSC_SHIFT))
        else $error("wide word closed at wrong time");
    // pins released while disabled
    a_sdo_release: assert property (r.ctrl1[C1_SDO_DIS]
        |=> !sdo_oe_o)
        else $error("data out driven while disabled");
    a_sck_release: assert property (r.ctrl1[C1_SCK_DIS] ##1
        r.ctrl1[C1_SCK_DIS] |-> !sck_oe_o)
        else $error("serial clock driven while disabled");
endmodule // sbsc_top

`default_nettype wire

// *** verif/sbsc_peer.sv ***
// Purpose: behavioural spi peer facing the buffer status block
// Assumes: mode 0, msb first, the same word answered on every frame
// Notes: slave to the block's clock, or makes the clock itself
`timescale 1ns/1ps
`default_nettype none
module sbsc_peer
(
    // pins driven by the block
    input wire logic sck_o_i,
    input wire logic sck_oe_i,
    input wire logic sdo_i,
    // lines seen by the block
    output logic sck_line_o,
    output logic sdi_line_o
);
    logic [15:0] tx_word = 16'h0000;
    logic [15:0] rx_word = 16'h0000;
    logic sck_own = 1'b0;
    int nbits = 8;
    int cnt = 0;
    // a released clock line follows the peer's own clock, low between frames
    assign sck_line_o = sck_oe_i ? sck_o_i : sck_own;
    // capture data out on the rising edge, msb first
    always @(posedge sck_line_o)
    begin
        rx_word <= {rx_word[14:0], sdo_i};
        cnt <= (cnt == nbits - 1) ? 0 : cnt + 1;
    end
    // the next bit goes out on the falling edge
    always @(negedge sck_line_o)
    begin
        sdi_line_o <= tx_word[nbits - 1 - cnt];
    end
    // load the word that every later frame answers with
    task automatic prime(input logic [15:0] w, input int n);
        tx_word = w;
        nbits = n;
        cnt = 0;
        sdi_line_o = w[n - 1];
    endtask
    // one frame of clock at an 800 ns period, still outside frames
    task automatic frame(input int n);
        #20; // keep link edges off the block's clock edges
        repeat (n)
        begin
            #400 sck_own = 1'b1;
            #400 sck_own = 1'b0;
        end
    endtask
endmodule // sbsc_peer
`default_nettype wire

// *** verif/spi_buffer_status_control_tb.sv ***
// Purpose: self-checking bench for the buffer status block
// Assumes: apb master, peer model on the serial pins
// Notes: random data from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module spi_buffer_status_control_tb
    import sbsc_pkg::*;
;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic pready, pslverr, sck_o, sck_oe, sdo, sdo_oe, irq;
    logic sck_line, sdi_line, err;
    logic [31:0] prdata, q;
    int bad_count = 0;
    int cmp_count = 0;
    // clock at 10 MHz
    always #50 clock_i = ~clock_i;
    sbsc_top u_sbsc_top (.clock_i(clock_i), .reset_i(reset_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
        .prdata_o(prdata), .pslverr_o(pslverr), .sck_i(sck_line),
        .sck_o(sck_o), .sck_oe_o(sck_oe), .sdi_i(sdi_line), .sdo_o(sdo),
        .sdo_oe_o(sdo_oe), .irq_o(irq));
    sbsc_peer u_sbsc_peer (.sck_o_i(sck_o), .sck_oe_i(sck_oe),
        .sdo_i(sdo), .sck_line_o(sck_line), .sdi_line_o(sdi_line));
    // compare and count
    task automatic chk(input logic [31:0] s, input logic [31:0] e,
        input string m);
        cmp_count++;
        if (s !== e)
        begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    // one apb transfer; read data and error land in q and err
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge clock_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        // wait for the answer; only the watchdog ends a hang
        do
            @(posedge clock_i);
        while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // poll a status bit until it shows v, then compare
    task automatic status_wait(input int b, input logic v);
        int n;
        n = 0;
        do
        begin
            apb(1'b0, ADDR_STATUS, 32'h0);
            n++;
        end
        while (q[b] !== v && n < 400);
        chk({31'h0, q[b]}, {31'h0, v}, "status flag");
    endtask
    // expected word seen in a transfer of the chosen width
    function automatic logic [31:0] wexp(input logic [15:0] v,
        input logic wide);
        return wide ? {16'h0, v} : {24'h0, v[7:0]};
    endfunction
    // one standard mode word each way
    task automatic xfer_std(input logic wide, input logic mst,
        input logic msk);
        logic [15:0] d;
        logic [15:0] p;
        d = 16'($urandom);
        p = 16'($urandom);
        u_sbsc_peer.prime(p, wide ? 16 : 8);
        apb(1'b1, ADDR_INT_MASK, {30'h0, msk, msk});
        apb(1'b1, ADDR_STATUS, 32'h0);
        apb(1'b1, ADDR_CTRL1, (32'(wide) << C1_WIDE) |
            (32'(mst) << C1_MASTER));
        apb(1'b1, ADDR_DATA, {16'h0, d});
        status_wait(ST_TBF, 1'b1);
        apb(1'b1, ADDR_STATUS, 32'h1 << ST_ENABLE);
        status_wait(ST_TBF, 1'b0);
        if (!mst)
            u_sbsc_peer.frame(wide ? 16 : 8);
        status_wait(ST_RBF, 1'b1);
        chk({31'h0, irq}, {31'h0, msk}, "irq level");
        apb(1'b0, ADDR_DATA, 32'h0);
        chk(q, wexp(p, wide), "received word");
        chk(wexp(u_sbsc_peer.rx_word, wide), wexp(d, wide), "sent");
        status_wait(ST_RBF, 1'b0);
        apb(1'b1, ADDR_INT_STAT, 32'h3);
        apb(1'b0, ADDR_INT_STAT, 32'h0);
        chk({q[30:0], irq}, 32'h0, "irq cleared");
        $display("test standard width %0d done", wide ? 16 : 8);
    endtask
    // verdict and end of run
    task automatic test_done();
        $display("compares %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // watchdog
    initial
    begin
        #3000000;
        bad_count++;
        $display("unexpected at %0t: watchdog ran out", $time);
        test_done();
    end
    // main sequence
    initial
    begin
        logic [15:0] w;
        void'($urandom(32'h8ad631aa));
        repeat (10) @(posedge clock_i);
        reset_i <= 1'b0;
        apb(1'b0, ADDR_CTRL1, 32'h0);
        chk(q, 32'h0, "control one reset");
        apb(1'b0, ADDR_INT_MASK, 32'h0);
        chk(q, 32'h0, "mask reset");
        apb(1'b0, 12'h018, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped error");
        $display("test reset done");
        for (int i = 0; i < 3; i++)
            xfer_std(i == 1, i < 2, i > 0);
        // enhanced buffer: fill while disabled, then drain
        w = 16'($urandom);
        u_sbsc_peer.prime(w, 8);
        apb(1'b1, ADDR_STATUS, 32'h0);
        apb(1'b1, ADDR_CTRL2, 32'h1 << C2_ENH);
        apb(1'b1, ADDR_CTRL1, 32'h1 << C1_MASTER);
        for (int i = 0; i < FIFO_DEPTH; i++)
        begin
            apb(1'b0, ADDR_STATUS, 32'h0);
            chk({31'h0, q[ST_TBF]}, 32'h0, "tx full early");
            apb(1'b1, ADDR_DATA, 32'($urandom) & 32'hff);
        end
        status_wait(ST_TBF, 1'b1);
        apb(1'b1, ADDR_STATUS, 32'h1 << ST_ENABLE);
        status_wait(ST_TBF, 1'b0);
        status_wait(ST_RX_EMPTY, 1'b0);
        chk({31'h0, q[ST_RBF]}, 32'h0, "rx full early");
        status_wait(ST_RBF, 1'b1);
        apb(1'b0, ADDR_DATA, 32'h0);
        status_wait(ST_RBF, 1'b0);
        for (int i = 1; i < FIFO_DEPTH; i++)
        begin
            apb(1'b0, ADDR_DATA, 32'h0);
            chk(q, wexp(w, 1'b0), "fifo word");
        end
        status_wait(ST_RX_EMPTY, 1'b1);
        status_wait(ST_SHIFT_IDLE, 1'b1);
        $display("test enhanced done");
        // pin release and drive
        apb(1'b1, ADDR_CTRL1, (32'h1 << C1_MASTER) |
            (32'h1 << C1_SCK_DIS) | (32'h1 << C1_SDO_DIS));
        apb(1'b0, ADDR_CTRL1, 32'h0);
        chk({30'h0, sck_oe, sdo_oe}, 32'h0, "pins released");
        apb(1'b1, ADDR_CTRL1, 32'h1 << C1_MASTER);
        apb(1'b0, ADDR_CTRL1, 32'h0);
        chk({30'h0, sck_oe, sdo_oe}, 32'h3, "pins driven");
        $display("test pins done");
        test_done();
    end
endmodule // spi_buffer_status_control_tb
`default_nettype wire
